// ===== shared/ext_irq_pkg.sv
// Overview of operation
// - Group 3 change sets flag bit 7
// - Group 2 change sets flag bit 6
// - Group 1 change sets flag bit 5
// - Group 0 change sets flag bit 4
// - External input event sets flag bit 0
// - Request needs global and source enable
// - Vector acceptance clears its flag
// - Writing one clears flag, zero ignored
// - Low-level sense holds flag at zero
// - Small variant reads group 3,2 flags zero
// - Group 3 mask bits 6:0 gate pins
// - Group 2 mask at 0x6D
// - Group 1 mask at 0x6C
// - Group 0 mask at 0x6B
// - Cleared mask bit blocks its pin
// - Group 3,2 masks only in large variant
// - Sense 00 low,01 change,10 fall,11 rise
// - Pulse over one clock always registers
// - Pins raise requests even as outputs
package ext_irq_pkg;
  localparam logic [7:0] mask_group0_addr = 8'h6B;
  localparam logic [7:0] mask_group1_addr = 8'h6C;
  localparam logic [7:0] mask_group2_addr = 8'h6D;
  localparam logic [7:0] mask_group3_addr = 8'h6E;
  localparam logic [7:0] flags_addr = 8'h6F;
  localparam logic [7:0] enable_addr = 8'h70;
  localparam logic [7:0] sense_addr = 8'h71;
  localparam int flag_ext0_bit = 0;
  localparam int group_flag_base = 4;
  localparam logic [7:0] reg_reset = 8'h00;
  localparam logic [7:0] group3_mask_valid = 8'h7F;
  localparam logic [7:0] large_flag_valid = 8'hF1;
  localparam logic [7:0] small_flag_valid = 8'h31;
  typedef enum logic [1:0] {
    sense_low = 2'b00,
    sense_change = 2'b01,
    sense_fall = 2'b10,
    sense_rise = 2'b11
  } sense_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;
endpackage

// ===== verilog/ext_pin_change_irq_flags.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module ext_pin_change_irq_flags #(
  parameter bit large_variant = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire ext_irq_pkg::bus_req_type bus_req,
  output logic [7:0] rdata,
  input wire logic [30:0] change_sense_pins,
  input wire logic ext_irq0_input,
  input wire logic global_irq_enable,
  input wire logic [4:0] vector_ack,
  output logic [4:0] irq_request
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [31:0] meta_q;
  logic [31:0] sync_q;
  logic [31:0] prev_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q <= 32'h0000_0000;
      sync_q <= 32'h0000_0000;
      prev_q <= 32'h0000_0000;
    end else begin
      meta_q <= {ext_irq0_input, change_sense_pins};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] mask_q [4];
  logic [7:0] enable_q;
  ext_irq_pkg::sense_type sense_q;
  logic [7:0] flags_q;
  logic wr_mask [4];
  always_comb begin
    wr_mask[0] = bus_req.wr && bus_req.addr == ext_irq_pkg::mask_group0_addr;
    wr_mask[1] = bus_req.wr && bus_req.addr == ext_irq_pkg::mask_group1_addr;
    wr_mask[2] = bus_req.wr && large_variant
      && bus_req.addr == ext_irq_pkg::mask_group2_addr;
    wr_mask[3] = bus_req.wr && large_variant
      && bus_req.addr == ext_irq_pkg::mask_group3_addr;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int g = 0; g < 4; g++) begin
        mask_q[g] <= ext_irq_pkg::reg_reset;
      end
    end else begin
      for (int g = 0; g < 4; g++) begin
        if (wr_mask[g]) begin
          mask_q[g] <= (g == 3) ? (bus_req.wdata & ext_irq_pkg::group3_mask_valid)
                                : bus_req.wdata;
        end
      end
    end
  end
  logic [7:0] enable_valid;
  assign enable_valid = large_variant ? ext_irq_pkg::large_flag_valid
                                      : ext_irq_pkg::small_flag_valid;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      enable_q <= ext_irq_pkg::reg_reset;
      sense_q <= ext_irq_pkg::sense_low;
    end else begin
      if (bus_req.wr && bus_req.addr == ext_irq_pkg::enable_addr) begin
        enable_q <= bus_req.wdata & enable_valid;
      end
      if (bus_req.wr && bus_req.addr == ext_irq_pkg::sense_addr) begin
        sense_q <= ext_irq_pkg::sense_type'(bus_req.wdata[1:0]);
      end
    end
  end

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  logic [7:0] set_ev;
  logic [30:0] changed;
  logic [31:0] changed_all;
  logic [3:0] group_hit;
  logic ext_now;
  logic ext_was;
  assign changed = sync_q[30:0] ^ prev_q[30:0];
  // Pad to four full groups; the group 3 mask top bit is held at zero
  assign changed_all = {1'b0, changed};
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      group_hit[g] = |(changed_all[g*8 +: 8] & mask_q[g]);
    end
  end
  assign ext_now = sync_q[31];
  assign ext_was = prev_q[31];
  always_comb begin
    set_ev = 8'h00;
    for (int g = 0; g < 4; g++) begin
      // A masked pin never contributes, enable or not
      set_ev[ext_irq_pkg::group_flag_base + g] = enable_q[ext_irq_pkg::group_flag_base + g]
        && group_hit[g];
    end
    unique case (sense_q)
      ext_irq_pkg::sense_change: set_ev[ext_irq_pkg::flag_ext0_bit] = ext_now ^ ext_was;
      ext_irq_pkg::sense_fall: set_ev[ext_irq_pkg::flag_ext0_bit] = ext_was && !ext_now;
      ext_irq_pkg::sense_rise: set_ev[ext_irq_pkg::flag_ext0_bit] = !ext_was && ext_now;
      ext_irq_pkg::sense_low: set_ev[ext_irq_pkg::flag_ext0_bit] = 1'b0;
    endcase
    set_ev = set_ev & enable_valid;
  end

  // ----------------------------------------
  // Request flags
  // ----------------------------------------
  logic [7:0] clr_ev;
  logic [7:0] flags_d;
  always_comb begin
    clr_ev = {vector_ack[4:1], 3'b000, vector_ack[0]};
    if (bus_req.wr && bus_req.addr == ext_irq_pkg::flags_addr) begin
      clr_ev = clr_ev | bus_req.wdata;
    end
    // Set wins so an event in the clear cycle survives
    flags_d = (flags_q & ~clr_ev) | set_ev;
    if (sense_q == ext_irq_pkg::sense_low) begin
      flags_d[ext_irq_pkg::flag_ext0_bit] = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_q <= ext_irq_pkg::reg_reset;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Level sense raises a live request while the pin is low
  logic low_req;
  assign low_req = sense_q == ext_irq_pkg::sense_low && !ext_now;
  always_comb begin
    irq_request[0] = global_irq_enable && enable_q[0] && (flags_q[0] || low_req);
    irq_request[4:1] = {4{global_irq_enable}} & enable_q[7:4] & flags_q[7:4];
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        ext_irq_pkg::mask_group0_addr: rdata <= mask_q[0];
        ext_irq_pkg::mask_group1_addr: rdata <= mask_q[1];
        ext_irq_pkg::mask_group2_addr: rdata <= large_variant ? mask_q[2] : 8'h00;
        ext_irq_pkg::mask_group3_addr: rdata <= large_variant ? mask_q[3] : 8'h00;
        ext_irq_pkg::flags_addr: rdata <= flags_q & enable_valid;
        ext_irq_pkg::enable_addr: rdata <= enable_q;
        ext_irq_pkg::sense_addr: rdata <= {6'b00_0000, sense_q};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence fall_seen;
    prev_q[31] && !sync_q[31] && sense_q == ext_irq_pkg::sense_fall;
  endsequence
  flag_low_sense_a: assert property (@(posedge clk) disable iff (!rstn)
    sense_q == ext_irq_pkg::sense_low |=> !flags_q[0]) else $error("ext flag set in low");
  ext_fall_set_a: assert property (@(posedge clk) disable iff (!rstn)
    fall_seen |=> flags_q[0]) else $error("fall missed");
  g0_change_set_a: assert property (@(posedge clk) disable iff (!rstn)
    enable_q[4] && |(changed[7:0] & mask_q[0]) |=> flags_q[4]) else $error("g0 missed");
  g1_change_set_a: assert property (@(posedge clk) disable iff (!rstn)
    enable_q[5] && |(changed[15:8] & mask_q[1]) |=> flags_q[5]) else $error("g1 missed");
  masked_no_set_a: assert property (@(posedge clk) disable iff (!rstn)
    !flags_q[4] && mask_q[0] == 8'h00 && !(vector_ack[0]) |=> !flags_q[4])
    else $error("masked set");
  w1c_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.wr && bus_req.addr == ext_irq_pkg::flags_addr && bus_req.wdata[5]
    && !set_ev[5] |=> !flags_q[5]) else $error("w1c failed");
  ack_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    vector_ack[2] && !set_ev[5] |=> !flags_q[5]) else $error("ack clear failed");
  gate_req_a: assert property (@(posedge clk) disable iff (!rstn)
    irq_request[3] |-> global_irq_enable && enable_q[6] && flags_q[6])
    else $error("ungated request");
  small_read_a: assert property (@(posedge clk) disable iff (!rstn)
    !large_variant && bus_req.rd && bus_req.addr == ext_irq_pkg::flags_addr
    |=> rdata[7:6] == 2'b00) else $error("reserved read");

  // ----------------------------------------
  // Assertions: flag setting
  // ----------------------------------------
  sequence rise_seen;
    !prev_q[31] && sync_q[31] && sense_q == ext_irq_pkg::sense_rise;
  endsequence
  sequence change_seen;
    (prev_q[31] ^ sync_q[31]) && sense_q == ext_irq_pkg::sense_change;
  endsequence
  ext_rise_set_a: assert property (@(posedge clk) disable iff (!rstn)
    rise_seen |=> flags_q[0]) else $error("rise missed");
  ext_change_set_a: assert property (@(posedge clk) disable iff (!rstn)
    change_seen |=> flags_q[0]) else $error("change missed");
  g2_change_set_a: assert property (@(posedge clk) disable iff (!rstn)
    enable_q[6] && |(changed[23:16] & mask_q[2]) |=> flags_q[6])
    else $error("g2 missed");
  g3_change_set_a: assert property (@(posedge clk) disable iff (!rstn)
    enable_q[7] && |(changed[30:24] & mask_q[3][6:0]) |=> flags_q[7])
    else $error("g3 missed");
  // A clear landing with a new event must not lose the event
  set_wins_a: assert property (@(posedge clk) disable iff (!rstn)
    set_ev[4] && vector_ack[1] |=> flags_q[4])
    else $error("ack beat set");
  w1c_set_wins_a: assert property (@(posedge clk) disable iff (!rstn)
    set_ev[5] && bus_req.wr && bus_req.addr == ext_irq_pkg::flags_addr
    |=> flags_q[5]) else $error("write beat set");
  ext_set_wins_a: assert property (@(posedge clk) disable iff (!rstn)
    set_ev[0] && vector_ack[0] |=> flags_q[0])
    else $error("ext ack beat set");

  // ----------------------------------------
  // Assertions: flag causes
  // ----------------------------------------
  // Every flag that rises must have had a cause one cycle before
  g0_cause_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(flags_q[4]) |-> $past(enable_q[4]) && $past(|(changed[7:0] & mask_q[0])))
    else $error("g0 set without cause");
  g1_cause_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(flags_q[5]) |-> $past(enable_q[5]) && $past(|(changed[15:8] & mask_q[1])))
    else $error("g1 set without cause");
  g2_cause_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(flags_q[6]) |-> $past(enable_q[6]) && $past(|(changed[23:16] & mask_q[2])))
    else $error("g2 set without cause");
  g3_cause_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(flags_q[7]) |-> $past(enable_q[7]) && $past(|(changed[30:24] & mask_q[3][6:0])))
    else $error("g3 set without cause");
  ext_cause_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(flags_q[0]) |-> $past(sense_q) != ext_irq_pkg::sense_low)
    else $error("ext set in low sense");
  g1_masked_a: assert property (@(posedge clk) disable iff (!rstn)
    !flags_q[5] && mask_q[1] == 8'h00 && !vector_ack[2] |=> !flags_q[5])
    else $error("g1 masked set");
  g2_masked_a: assert property (@(posedge clk) disable iff (!rstn)
    !flags_q[6] && mask_q[2] == 8'h00 && !vector_ack[3] |=> !flags_q[6])
    else $error("g2 masked set");
  g3_masked_a: assert property (@(posedge clk) disable iff (!rstn)
    !flags_q[7] && mask_q[3] == 8'h00 && !vector_ack[4] |=> !flags_q[7])
    else $error("g3 masked set");
  flag_reserved_a: assert property (@(posedge clk) disable iff (!rstn)
    flags_q[3:1] == 3'b000) else $error("reserved flag set");

  // ----------------------------------------
  // Assertions: flag clearing
  // ----------------------------------------
  ack0_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    vector_ack[1] && !set_ev[4] |=> !flags_q[4]) else $error("ack0 clear failed");
  ack2_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    vector_ack[3] && !set_ev[6] |=> !flags_q[6]) else $error("ack2 clear failed");
  ack3_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    vector_ack[4] && !set_ev[7] |=> !flags_q[7]) else $error("ack3 clear failed");
  ext_ack_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    vector_ack[0] && !set_ev[0] |=> !flags_q[0]) else $error("ext ack clear failed");
  w0_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.wr && bus_req.addr == ext_irq_pkg::flags_addr && !bus_req.wdata[4]
    && !vector_ack[1] && flags_q[4] |=> flags_q[4])
    else $error("zero write cleared flag");
  ext_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.wr && bus_req.addr == ext_irq_pkg::flags_addr && !bus_req.wdata[0]
    && !vector_ack[0] && flags_q[0] && sense_q != ext_irq_pkg::sense_low |=> flags_q[0])
    else $error("zero write cleared ext flag");

  // ----------------------------------------
  // Assertions: configuration registers
  // ----------------------------------------
  mask0_write_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.wr && bus_req.addr == ext_irq_pkg::mask_group0_addr
    |=> mask_q[0] == $past(bus_req.wdata)) else $error("mask0 write lost");
  mask1_write_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.wr && bus_req.addr == ext_irq_pkg::mask_group1_addr
    |=> mask_q[1] == $past(bus_req.wdata)) else $error("mask1 write lost");
  mask2_write_a: assert property (@(posedge clk) disable iff (!rstn)
    large_variant && bus_req.wr && bus_req.addr == ext_irq_pkg::mask_group2_addr
    |=> mask_q[2] == $past(bus_req.wdata)) else $error("mask2 write lost");
  mask3_write_a: assert property (@(posedge clk) disable iff (!rstn)
    large_variant && bus_req.wr && bus_req.addr == ext_irq_pkg::mask_group3_addr
    |=> mask_q[3] == ($past(bus_req.wdata) & ext_irq_pkg::group3_mask_valid))
    else $error("mask3 write lost");
  small_mask_a: assert property (@(posedge clk) disable iff (!rstn)
    !large_variant |-> mask_q[2] == 8'h00 && mask_q[3] == 8'h00) else $error("small mask");
  enable_write_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.wr && bus_req.addr == ext_irq_pkg::enable_addr
    |=> enable_q == ($past(bus_req.wdata) & enable_valid)) else $error("enable write lost");
  enable_reserved_a: assert property (@(posedge clk) disable iff (!rstn)
    enable_q[3:1] == 3'b000) else $error("reserved enable set");
  sense_write_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.wr && bus_req.addr == ext_irq_pkg::sense_addr
    |=> sense_q == $past(bus_req.wdata[1:0])) else $error("sense write lost");

  // ----------------------------------------
  // Assertions: requests to the core
  // ----------------------------------------
  sequence low_live;
    sense_q == ext_irq_pkg::sense_low && !sync_q[31];
  endsequence
  // Level requests are live, so the core sees them as long as the pin stays low
  low_req_a: assert property (@(posedge clk) disable iff (!rstn)
    low_live ##0 (global_irq_enable && enable_q[0]) |-> irq_request[0]) else $error("low lost");
  gate0_req_a: assert property (@(posedge clk) disable iff (!rstn)
    irq_request[0] |-> global_irq_enable && enable_q[0]) else $error("ungated ext");
  gate1_req_a: assert property (@(posedge clk) disable iff (!rstn)
    irq_request[1] |-> global_irq_enable && enable_q[4] && flags_q[4]) else $error("ungated g0");
  gate2_req_a: assert property (@(posedge clk) disable iff (!rstn)
    irq_request[2] |-> global_irq_enable && enable_q[5] && flags_q[5]) else $error("ungated g1");
  gate4_req_a: assert property (@(posedge clk) disable iff (!rstn)
    irq_request[4] |-> global_irq_enable && enable_q[7] && flags_q[7]) else $error("ungated g3");
  req_g0_a: assert property (@(posedge clk) disable iff (!rstn)
    global_irq_enable && enable_q[4] && flags_q[4] |-> irq_request[1]) else $error("g0 req lost");
  req_g1_a: assert property (@(posedge clk) disable iff (!rstn)
    global_irq_enable && enable_q[5] && flags_q[5] |-> irq_request[2]) else $error("g1 req lost");
  req_g2_a: assert property (@(posedge clk) disable iff (!rstn)
    global_irq_enable && enable_q[6] && flags_q[6] |-> irq_request[3]) else $error("g2 req lost");
  req_g3_a: assert property (@(posedge clk) disable iff (!rstn)
    global_irq_enable && enable_q[7] && flags_q[7] |-> irq_request[4]) else $error("g3 req lost");

  // ----------------------------------------
  // Assertions: read port
  // ----------------------------------------
  flags_read_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.rd && bus_req.addr == ext_irq_pkg::flags_addr
    |=> rdata == ($past(flags_q) & enable_valid)) else $error("flags read wrong");
  mask0_read_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.rd && bus_req.addr == ext_irq_pkg::mask_group0_addr
    |=> rdata == $past(mask_q[0])) else $error("mask0 read wrong");
  mask1_read_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.rd && bus_req.addr == ext_irq_pkg::mask_group1_addr
    |=> rdata == $past(mask_q[1])) else $error("mask1 read wrong");
  mask2_read_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.rd && bus_req.addr == ext_irq_pkg::mask_group2_addr
    |=> rdata == (large_variant ? $past(mask_q[2]) : 8'h00)) else $error("mask2 read wrong");
  mask3_read_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.rd && bus_req.addr == ext_irq_pkg::mask_group3_addr
    |=> rdata == (large_variant ? $past(mask_q[3]) : 8'h00)) else $error("mask3 read wrong");
  enable_read_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.rd && bus_req.addr == ext_irq_pkg::enable_addr
    |=> rdata == $past(enable_q)) else $error("enable read wrong");
  sense_read_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_req.rd && bus_req.addr == ext_irq_pkg::sense_addr
    |=> rdata[1:0] == $past(sense_q)) else $error("sense read wrong");
  idle_read_a: assert property (@(posedge clk) disable iff (!rstn)
    !bus_req.rd |=> rdata == 8'h00) else $error("read data not idle");

  // ----------------------------------------
  // Assertions: reset and synchroniser
  // ----------------------------------------
  reset_clear_a: assert property (@(posedge clk)
    !rstn |=> flags_q == 8'h00 && enable_q == 8'h00 && mask_q[0] == 8'h00)
    else $error("reset left state");
  sync_stage_a: assert property (@(posedge clk) disable iff (!rstn)
    sync_q == $past(meta_q)) else $error("sync stage skipped");
endmodule

// ===== test/cpu_pin_partner.sv
`timescale 1ns/1ps
// ----
// Far side: pins and CPU vector acceptance
// ----
module cpu_pin_partner (
  input wire logic clk,
  input wire logic [30:0] pins_cmd,
  input wire logic ext_cmd,
  input wire logic auto_ack,
  input wire logic [4:0] irq_request,
  output logic [30:0] change_sense_pins = '0,
  output logic ext_irq0_input = 1'b0,
  output logic [4:0] vector_ack = 5'h00
);
  // Pins may be outputs of the chip; they still feed the detector
  always_ff @(posedge clk) begin
    change_sense_pins <= pins_cmd;
    ext_irq0_input <= ext_cmd;
  end
  // One pulse per flag request, as the flag drops a cycle later; a live low-level request gets a pulse every other cycle
  always_ff @(posedge clk) begin
    vector_ack <= auto_ack ? (irq_request & ~vector_ack) : 5'h00;
  end
endmodule

// ===== test/ext_pin_change_irq_flags_tb_top.sv
`timescale 1ns/1ps
module ext_pin_change_irq_flags_tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  ext_irq_pkg::bus_req_type bus_req = '0;
  logic [7:0] rdata;
  logic [30:0] pins_cmd = '0;
  logic ext_cmd = 1'b0;
  logic auto_ack = 1'b0;
  logic global_irq_enable = 1'b0;
  logic [30:0] change_sense_pins;
  logic ext_irq0_input;
  logic [4:0] vector_ack;
  logic [4:0] irq_request;
  int errors = 0;
  int checks = 0;
  always #10 clk = ~clk;
  ext_pin_change_irq_flags dut_u (.clk(clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
    .change_sense_pins(change_sense_pins), .ext_irq0_input(ext_irq0_input),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack), .irq_request(irq_request));
  cpu_pin_partner far_u (.clk(clk), .pins_cmd(pins_cmd), .ext_cmd(ext_cmd), .auto_ack(auto_ack),
    .irq_request(irq_request), .change_sense_pins(change_sense_pins),
    .ext_irq0_input(ext_irq0_input), .vector_ack(vector_ack));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1 chk(rdata, exp);
  endtask
  // Pulse lasts two clocks: long enough to be guaranteed
  task automatic pulse(input int idx);
    @(posedge clk);
    pins_cmd[idx] <= 1'b1;
    repeat (2) @(posedge clk);
    pins_cmd[idx] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic ext_drive(input logic lvl);
    @(posedge clk);
    ext_cmd <= lvl;
    repeat (6) @(posedge clk);
  endtask
  task automatic gie(input logic en);
    @(posedge clk);
    global_irq_enable <= en;
    @(posedge clk);
  endtask
  task final_report;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end
  // ----
  // Tests
  // ----
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 8'h6B; a <= 8'h72; a++) rd(8'(a), 8'h00);
    for (int g = 0; g < 4; g++) begin
      wr(8'(8'h6B + g), 8'hFF);
      rd(8'(8'h6B + g), (g == 3) ? 8'h7F : 8'hFF);
      wr(8'(8'h6B + g), 8'h01);
    end
    wr(ext_irq_pkg::enable_addr, 8'hF1);
    for (int g = 0; g < 4; g++) begin
      pulse(g * 8 + 1);
      rd(ext_irq_pkg::flags_addr, 8'h00);
      pulse(g * 8);
      rd(ext_irq_pkg::flags_addr, 8'h10 << g);
      chk({3'b000, irq_request}, 8'h00);
      gie(1'b1);
      #1 chk({3'b000, irq_request}, (8'h02 << g) | 8'h01);
      gie(1'b0);
      wr(ext_irq_pkg::flags_addr, 8'h00);
      rd(ext_irq_pkg::flags_addr, 8'h10 << g);
      wr(ext_irq_pkg::flags_addr, 8'h10 << g);
      rd(ext_irq_pkg::flags_addr, 8'h00);
    end
    gie(1'b1);
    auto_ack <= 1'b1;
    pulse(0);
    rd(ext_irq_pkg::flags_addr, 8'h00);
    auto_ack <= 1'b0;
    for (int s = 1; s < 4; s++) begin
      wr(ext_irq_pkg::sense_addr, 8'(s));
      ext_drive(1'b1);
      rd(ext_irq_pkg::flags_addr, {7'h00, s != 2});
      wr(ext_irq_pkg::flags_addr, 8'h01);
      ext_drive(1'b0);
      rd(ext_irq_pkg::flags_addr, {7'h00, s != 3});
      wr(ext_irq_pkg::flags_addr, 8'h01);
    end
    wr(ext_irq_pkg::sense_addr, 8'h00);
    ext_drive(1'b0);
    #1 chk({3'b000, irq_request}, 8'h01);
    rd(ext_irq_pkg::flags_addr, 8'h00);
    ext_drive(1'b1);
    #1 chk({3'b000, irq_request}, 8'h00);
    ext_drive(1'b0);
    rd(ext_irq_pkg::flags_addr, 8'h00);
    final_report();
  end
endmodule
